// >>> hdl/sleep_wake_ctrl.sv
/*
 * Low-power mode and wake-up control: deep sleep, core idle, recovery sequence and reset cause flags.
 * Assumes the core pulses sleep and idle requests on sys_clk_i, and that this block sits in an always-on domain.
 */
`timescale 1ns/1ps
module sleep_wake_ctrl
    import sleep_wake_pkg::*;
#(
    parameter int unsigned GPIO_W      = sleep_wake_pkg::GPIO_WIDTH,
    parameter int unsigned RECOVER_CYC = sleep_wake_pkg::RECOVERY_CYCLES,
    parameter int unsigned MIN_PULSE   = sleep_wake_pkg::MIN_WAKE_CYCLES
) (
    input  wire logic                           sys_clk_i,
    input  wire logic                           rstn_i,
    input  wire logic                           sleep_req_i,
    input  wire logic                           idle_req_i,
    input  wire logic                           wake_irq_i,
    input  wire sleep_wake_pkg::watchdog_ctl_t  wdog_i,
    input  wire logic                           irq_enable_i,
    input  wire logic [GPIO_W-1:0]              gpio_pin_i,
    input  wire logic [GPIO_W-1:0]              gpio_wake_en_i,
    input  wire logic                           ext_resetn_i,
    input  wire logic                           debug_pin_i,
    input  wire logic                           brownout_sleep_opt_i,
    input  wire logic                           amp_sleep_en_i,
    input  wire logic                           brownout_en_i,
    input  wire logic                           amp_en_i,
    input  wire logic [GPIO_W-1:0]              periph_en_i,
    input  wire logic                           osc_ready_i,
    input  wire logic                           cause_clear_i,
    output sleep_wake_pkg::power_ctl_t          power_o,
    output logic [GPIO_W-1:0]                   periph_run_o,
    output logic [GPIO_W-1:0]                   port_input_latch_o,
    output logic [CAUSE_WIDTH-1:0]              reset_cause_register_o,
    output logic                                system_reset_o,
    output logic                                wdog_irq_o,
    output logic                                sleep_wake_recovery_o,
    output power_mode_t                         mode_o
);
    import sleep_wake_pkg::*;

    localparam int unsigned RW = $clog2(RECOVER_CYC + 1);

    initial begin
        if (GPIO_W < 1 || RECOVER_CYC < 1 || MIN_PULSE < 1) begin
            $error("sleep_wake_ctrl parameters must all be at least one.");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and wake detectors.
    logic [GPIO_W-1:0] pin_level;
    logic [GPIO_W-1:0] pin_wake;
    logic [GPIO_W-1:0] pin_glitch;
    logic              asleep;

    genvar g;
    generate
        for (g = 0; g < GPIO_W; g++) begin : gen_pin
            wake_pin_watch #(
                .MIN_CYCLES (MIN_PULSE)
            ) u_watch (
                .sys_clk_i (sys_clk_i),
                .rstn_i    (rstn_i),
                .pin_i     (gpio_pin_i[g]),
                .arm_i     (asleep & gpio_wake_en_i[g]),
                .level_o   (pin_level[g]),
                .wake_o    (pin_wake[g]),
                .glitch_o  (pin_glitch[g])
            );
        end
    endgenerate

    logic ext_meta_r;
    logic ext_sync_r;
    logic dbg_meta_r;
    logic dbg_sync_r;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_meta_r <= 1'b1;
            ext_sync_r <= 1'b1;
            dbg_meta_r <= 1'b1;
            dbg_sync_r <= 1'b1;
        end else begin
            ext_meta_r <= ext_resetn_i;
            ext_sync_r <= ext_meta_r;
            dbg_meta_r <= debug_pin_i;
            dbg_sync_r <= dbg_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode state machine.
    power_mode_t   state_r;
    power_mode_t   state_nxt;
    logic [RW-1:0] delay_r;
    logic          wdog_wake;
    logic          gpio_wake;
    logic          gpio_glitch;
    logic          hard_reset;
    logic          recover_done;
    logic          from_wdog_r;
    logic          irq_pending_r;

    // Pin and watchdog wake and reset requests are only honoured while in deep sleep.
    assign asleep       = (state_r == MODE_SLEEP);
    assign wdog_wake    = asleep && wdog_i.timeout && wdog_i.logic_enable && wdog_i.osc_enable;
    assign gpio_wake    = asleep && (|pin_wake);
    assign gpio_glitch  = asleep && (|pin_glitch);
    assign hard_reset   = asleep && (!ext_sync_r || !dbg_sync_r);
    assign recover_done = (state_r == MODE_RECOVER) && (delay_r == '0) && osc_ready_i;

    // A reset pin beats every wake source in the same cycle.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            MODE_ACTIVE: begin
                if (sleep_req_i) begin
                    state_nxt = MODE_SLEEP;
                end else if (idle_req_i) begin
                    state_nxt = MODE_IDLE;
                end
            end
            MODE_IDLE: begin
                if (wake_irq_i) begin
                    state_nxt = MODE_ACTIVE;
                end
            end
            MODE_SLEEP: begin
                if (hard_reset) begin
                    state_nxt = MODE_ACTIVE;
                end else if (wdog_wake || gpio_wake) begin
                    state_nxt = MODE_RECOVER;
                end
            end
            MODE_RECOVER: begin
                if (recover_done) begin
                    state_nxt = MODE_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= MODE_ACTIVE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Recovery delay counter.
    // It is loaded on the way into recovery, then counted down to zero.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            delay_r <= '0;
        end else if (state_r == MODE_SLEEP && state_nxt == MODE_RECOVER) begin
            delay_r <= RW'(RECOVER_CYC);
        end else if (state_r == MODE_RECOVER && delay_r != '0) begin
            delay_r <= delay_r - RW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake source memory and watchdog interrupt after recovery.
    // The interrupt stands for the first active cycle after recovery.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            from_wdog_r <= 1'b0;
        end else if (state_r == MODE_SLEEP && state_nxt == MODE_RECOVER) begin
            from_wdog_r <= wdog_wake && !wdog_i.reset_mode;
        end else if (recover_done) begin
            from_wdog_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_pending_r <= 1'b0;
        end else if (recover_done && from_wdog_r && irq_enable_i) begin
            irq_pending_r <= 1'b1;
        end else if (state_r != MODE_ACTIVE) begin
            irq_pending_r <= irq_pending_r;
        end else begin
            irq_pending_r <= 1'b0;
        end
    end

    assign wdog_irq_o = irq_pending_r;

    ////////////////////////////////////////////////////////////////////////////
    // Full system reset pulse.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            system_reset_o <= 1'b0;
        end else begin
            system_reset_o <= hard_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset cause flags; a hardware set wins over a software clear.
    // A clear and a set in the same cycle leave the set bit high.
    logic [CAUSE_WIDTH-1:0] cause_r;
    logic [CAUSE_WIDTH-1:0] cause_set;

    always_comb begin
        cause_set = '0;
        cause_set[CAUSE_RECOVERY_BIT] = recover_done || gpio_glitch || wdog_wake;
        cause_set[CAUSE_WATCHDOG_BIT] = wdog_wake;
        cause_set[CAUSE_EXTRESET_BIT] = asleep && !ext_sync_r;
        cause_set[CAUSE_DEBUG_BIT]    = asleep && !dbg_sync_r;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cause_r <= CAUSE_RESET_VALUE;
        end else if (cause_clear_i) begin
            cause_r <= cause_set;
        end else begin
            cause_r <= cause_r | cause_set;
        end
    end

    assign reset_cause_register_o = cause_r;

    ////////////////////////////////////////////////////////////////////////////
    // Port input latch: frozen asleep, takes only the levels that survive recovery.
    // Short pulses during sleep therefore never reach the latch.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_input_latch_o <= '0;
        end else if (state_r == MODE_ACTIVE || state_r == MODE_IDLE || recover_done) begin
            port_input_latch_o <= pin_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power and clock controls.
    // Every control except watchdog_osc_run and watchdog_run follows the next state, so it changes together with mode_o.
    logic deep;
    logic recov;

    assign deep  = (state_r == MODE_SLEEP);
    assign recov = (state_r == MODE_RECOVER);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            power_o <= '{default: 1'b1};
        end else begin
            power_o.osc_run          <= !(state_nxt == MODE_SLEEP);
            power_o.crystal_pins_en  <= !(state_nxt == MODE_SLEEP);
            power_o.sys_clk_run      <= (state_nxt == MODE_ACTIVE || state_nxt == MODE_IDLE);
            power_o.core_run         <= (state_nxt == MODE_ACTIVE);
            power_o.peripheral_run   <= (state_nxt == MODE_ACTIVE || state_nxt == MODE_IDLE);
            power_o.brownout_run     <= brownout_en_i && (!(state_nxt == MODE_SLEEP) || brownout_sleep_opt_i);
            power_o.amp_run          <= amp_en_i && (!(state_nxt == MODE_SLEEP) || amp_sleep_en_i);
            power_o.watchdog_osc_run <= wdog_i.osc_enable;
            power_o.watchdog_run     <= wdog_i.logic_enable;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            periph_run_o <= '1;
        end else if (state_nxt == MODE_ACTIVE || state_nxt == MODE_IDLE) begin
            periph_run_o <= periph_en_i;
        end else begin
            periph_run_o <= '0;
        end
    end

    assign sleep_wake_recovery_o = recov || deep;
    assign mode_o                = state_r;

endmodule

// >>> hdl/wake_pin_watch.sv
/*
 * Watches one wake pin: synchronises it, and flags a level change that lasts the minimum pulse width.
 * Assumes the pin is asynchronous to sys_clk_i and that arm_i is high only while asleep.
 */
`timescale 1ns/1ps
module wake_pin_watch #(
    parameter int unsigned MIN_CYCLES = 10
) (
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    input  wire logic pin_i,
    input  wire logic arm_i,
    output logic      level_o,
    output logic      wake_o,
    output logic      glitch_o
);
    import sleep_wake_pkg::*;

    localparam int unsigned CW = $clog2(MIN_CYCLES + 1);

    initial begin
        if (MIN_CYCLES < 1) begin
            $error("wake_pin_watch needs MIN_CYCLES of at least one.");
        end
    end

    logic          meta_r;
    logic          sync_r;
    logic          ref_r;
    logic [CW-1:0] hold_r;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference level tracks the pin while disarmed; a change is timed while armed.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_r  <= 1'b0;
            hold_r <= '0;
        end else if (!arm_i) begin
            ref_r  <= sync_r;
            hold_r <= '0;
        end else if (sync_r != ref_r) begin
            if (hold_r < CW'(MIN_CYCLES)) begin
                hold_r <= hold_r + CW'(1);
            end
        end else begin
            hold_r <= '0;
        end
    end

    assign level_o  = sync_r;
    assign wake_o   = arm_i && (sync_r != ref_r) && (hold_r >= CW'(MIN_CYCLES));
    assign glitch_o = arm_i && (sync_r == ref_r) && (hold_r != '0);

endmodule

// >>> include/sleep_wake_pkg.sv
/*
 * Constants and carrier types for the low-power sleep and wake controller.
 * Assumes a single 200 MHz system clock that keeps running in this block's always-on domain.
 */
package sleep_wake_pkg;

    localparam int unsigned CLK_MHZ            = 200;
    localparam int unsigned RECOVERY_DELAY_NS  = 1000;
    localparam int unsigned RECOVERY_CYCLES    = (RECOVERY_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned MIN_WAKE_PULSE_NS  = 50;
    localparam int unsigned MIN_WAKE_CYCLES    = (MIN_WAKE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned GPIO_WIDTH         = 8;

    localparam int unsigned CAUSE_WATCHDOG_BIT = 0;
    localparam int unsigned CAUSE_RECOVERY_BIT = 1;
    localparam int unsigned CAUSE_EXTRESET_BIT = 2;
    localparam int unsigned CAUSE_DEBUG_BIT    = 3;
    localparam int unsigned CAUSE_WIDTH        = 4;
    localparam logic [3:0]  CAUSE_RESET_VALUE  = 4'h0;

    typedef enum logic [3:0] {
        MODE_ACTIVE   = 4'b0001,
        MODE_IDLE     = 4'b0010,
        MODE_SLEEP    = 4'b0100,
        MODE_RECOVER  = 4'b1000
    } power_mode_t;

    typedef struct packed {
        logic timeout;
        logic reset_mode;
        logic osc_enable;
        logic logic_enable;
    } watchdog_ctl_t;

    typedef struct packed {
        logic osc_run;
        logic sys_clk_run;
        logic core_run;
        logic peripheral_run;
        logic brownout_run;
        logic amp_run;
        logic watchdog_osc_run;
        logic watchdog_run;
        logic crystal_pins_en;
    } power_ctl_t;

endpackage

// >>> testbench/low_power_sleep_wake_control_tb.sv
/* Self-checking bench for the sleep and wake controller.
   Drives core, watchdog and reset inputs; the far-side model holds the pins. */
`timescale 1ns/1ps
module low_power_sleep_wake_control_tb;
    import sleep_wake_pkg::*;
    logic sys_clk_i = 1'b0, rstn_i = 1'b0, sleep_req_i = 1'b0, idle_req_i = 1'b0, wake_irq_i = 1'b0;
    logic irq_enable_i = 1'b0, ext_resetn_i = 1'b1, debug_pin_i = 1'b1, cause_clear_i = 1'b0, osc_ready_i;
    logic brownout_sleep_opt_i = 1'b0, amp_sleep_en_i = 1'b0, brownout_en_i = 1'b0, amp_en_i = 1'b0, slow = 1'b0;
    logic [7:0] gpio_pin_i, gpio_wake_en_i = 8'h00, periph_en_i = 8'hFF, flip = 8'h00, m;
    logic [7:0] periph_run_o, port_input_latch_o;
    logic [3:0] reset_cause_register_o;
    logic system_reset_o, wdog_irq_o, swr;
    logic [1:0] seen;
    watchdog_ctl_t wdog_i = '0;
    power_ctl_t power_o;
    power_mode_t mode_o, prev = MODE_ACTIVE;
    logic [5:0] exp_q[$];
    logic [31:0] seed = 32'h0C1F3197;
    int checks_done = 0, miscompares = 0, k;
    always #2.5 sys_clk_i = ~sys_clk_i;
    sleep_wake_ctrl #(.RECOVER_CYC(4), .MIN_PULSE(2)) dut (.sys_clk_i, .rstn_i, .sleep_req_i, .idle_req_i,
        .wake_irq_i, .wdog_i, .irq_enable_i, .gpio_pin_i, .gpio_wake_en_i, .ext_resetn_i, .debug_pin_i,
        .brownout_sleep_opt_i, .amp_sleep_en_i, .brownout_en_i, .amp_en_i, .periph_en_i, .osc_ready_i,
        .cause_clear_i, .power_o, .periph_run_o, .port_input_latch_o, .reset_cause_register_o, .system_reset_o,
        .wdog_irq_o, .sleep_wake_recovery_o(swr), .mode_o);
    wake_side_model model (.sys_clk_i, .rstn_i, .flip_i(flip), .asleep_i(mode_o == MODE_SLEEP), .slow_i(slow),
        .pins_o(gpio_pin_i), .osc_ready_o(osc_ready_i));
    //////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_mode(input power_mode_t w, input int n);
        for (int i = 0; i < n && mode_o !== w; i++) tick();
        if (mode_o !== w) begin
            check(8'(mode_o), 8'(w));
            close_out();
        end
    endtask
    task automatic go_sleep(input logic [1:0] wd);
        cause_clear_i = 1'b1;
        tick();
        cause_clear_i = 1'b0;
        seed = xs(seed);
        {brownout_sleep_opt_i, amp_sleep_en_i, brownout_en_i, amp_en_i, slow} = seed[4:0];
        {wdog_i.logic_enable, wdog_i.osc_enable} = wd;
        sleep_req_i = 1'b1;
        tick();
        sleep_req_i = 1'b0;
        wait_mode(MODE_SLEEP, 3);
        tick(3);
    endtask
    task automatic wake_on(input logic [7:0] f);
        flip = f;
        tick();
        flip = 8'h00;
        wait_mode(MODE_ACTIVE, 40);
        tick(3);
    endtask
    //////////////////////////////////////////////////////////////////////
    // Scoreboard: each wake from sleep or reset is compared with the oldest note.
    always begin
        @(posedge sys_clk_i);
        #2;
        if (rstn_i && ((prev == MODE_RECOVER && mode_o == MODE_ACTIVE) || system_reset_o)) begin
            seen = {wdog_irq_o, system_reset_o};
            @(posedge sys_clk_i);
            #2;
            seen[1] = seen[1] | wdog_irq_o;
            check({2'b00, seen, reset_cause_register_o}, exp_q.size() ? {2'b00, exp_q.pop_front()} : 8'hFF);
        end
        prev = mode_o;
    end
    initial begin
        tick(4);
        rstn_i = 1'b1;
        tick(2);
        repeat (3) begin
            seed = xs(seed);
            periph_en_i = seed[15:8];
            tick(2);
            check(periph_run_o, periph_en_i);
        end
        $display("test active enables done");
        repeat (4) begin
            seed = xs(seed);
            m = 8'h01 << seed[10:8];
            gpio_wake_en_i = seed[23:16] | m;
            go_sleep(seed[1:0]);
            exp_q.push_back(6'h02);
            wake_on(m | (seed[31:24] & ~gpio_wake_en_i));
            check(port_input_latch_o, gpio_pin_i);
        end
        $display("test pin wake done");
        gpio_wake_en_i = 8'h10;
        go_sleep(2'b00);
        flip = 8'h10;
        tick(2);
        flip = 8'h00;
        tick(8);
        check({mode_o, reset_cause_register_o}, {MODE_SLEEP, 4'h2});
        check(periph_run_o, 8'h00);
        check(8'(swr), 8'h01);
        exp_q.push_back(6'h02);
        wake_on(8'h10);
        $display("test short pulse done");
        for (k = 0; k < 3; k++) begin
            wdog_i.reset_mode = (k == 0);
            irq_enable_i = (k == 1);
            go_sleep(2'b11);
            exp_q.push_back({k == 1, 5'h03});
            wdog_i.timeout = 1'b1;
            wake_on(8'h00);
            wdog_i.timeout = 1'b0;
        end
        $display("test watchdog wake done");
        for (k = 0; k < 2; k++) begin
            go_sleep(2'b01);
            exp_q.push_back(k ? 6'h18 : 6'h14);
            ext_resetn_i = (k != 0);
            debug_pin_i = (k == 0);
            tick(4);
            ext_resetn_i = 1'b1;
            debug_pin_i = 1'b1;
            wait_mode(MODE_ACTIVE, 20);
            tick(3);
        end
        $display("test reset pins done");
        idle_req_i = 1'b1;
        tick();
        idle_req_i = 1'b0;
        wait_mode(MODE_IDLE, 3);
        sleep_req_i = 1'b1;
        tick();
        sleep_req_i = 1'b0;
        tick(2);
        check({mode_o, 2'b00, power_o.core_run, power_o.peripheral_run}, {MODE_IDLE, 4'h1});
        wake_irq_i = 1'b1;
        wait_mode(MODE_ACTIVE, 5);
        wake_irq_i = 1'b0;
        $display("test idle done");
        tick(5);
        check(8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule

// >>> testbench/sleep_wake_checker.sv
/* Assertion checker for the sleep and wake controller.
   Sees only the top module's ports and is bound to it below. */
`timescale 1ns/1ps
module sleep_wake_checker
    import sleep_wake_pkg::*;
#(
    parameter int unsigned GPIO_W    = 8,
    parameter int unsigned MIN_PULSE = 2
) (
    input wire logic                          sys_clk_i,
    input wire logic                          rstn_i,
    input wire logic                          sleep_req_i,
    input wire sleep_wake_pkg::watchdog_ctl_t wdog_i,
    input wire logic [GPIO_W-1:0]             gpio_pin_i,
    input wire logic [GPIO_W-1:0]             gpio_wake_en_i,
    input wire logic                          ext_resetn_i,
    input wire logic                          debug_pin_i,
    input wire logic                          brownout_sleep_opt_i,
    input wire logic                          amp_sleep_en_i,
    input wire logic                          osc_ready_i,
    input wire sleep_wake_pkg::power_ctl_t    power_o,
    input wire logic [GPIO_W-1:0]             port_input_latch_o,
    input wire logic [CAUSE_WIDTH-1:0]        reset_cause_register_o,
    input wire logic                          system_reset_o,
    input wire sleep_wake_pkg::power_mode_t   mode_o
);
    localparam int WAKE_MAX = MIN_PULSE + 6;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    //////////////////////////////////////////////////////////////////////
    sequence s_quiet; $stable(gpio_pin_i)[*3]; endsequence
    sequence s_move;
        mode_o == MODE_SLEEP && ext_resetn_i && debug_pin_i && !wdog_i.timeout
            && $changed(gpio_pin_i & gpio_wake_en_i);
    endsequence
    sequence s_dog; mode_o == MODE_SLEEP && wdog_i.timeout && wdog_i.osc_enable && wdog_i.logic_enable; endsequence
    property p_enter; mode_o == MODE_ACTIVE && sleep_req_i |=> mode_o == MODE_SLEEP; endproperty
    property p_off;
        mode_o == MODE_SLEEP |-> !(power_o.osc_run | power_o.sys_clk_run | power_o.core_run
            | power_o.peripheral_run | power_o.crystal_pins_en);
    endproperty
    property p_dog_keep;
        mode_o == MODE_SLEEP && $past(mode_o) == MODE_SLEEP |-> power_o.watchdog_osc_run == $past(wdog_i.osc_enable)
            && (!power_o.watchdog_run || $past(wdog_i.logic_enable));
    endproperty
    property p_bo_amp;
        mode_o == MODE_SLEEP |-> (!power_o.brownout_run || brownout_sleep_opt_i) && (!power_o.amp_run || amp_sleep_en_i);
    endproperty
    property p_idle;
        mode_o == MODE_IDLE |-> !power_o.core_run && power_o.sys_clk_run && power_o.osc_run && power_o.peripheral_run;
    endproperty
    property p_ext; mode_o == MODE_SLEEP && !ext_resetn_i |-> ##[1:4] system_reset_o; endproperty
    property p_dbg; mode_o == MODE_SLEEP && !debug_pin_i |-> ##[1:4] system_reset_o; endproperty
    property p_dog_cause;
        s_dog |-> ##[1:3] reset_cause_register_o[CAUSE_WATCHDOG_BIT] && reset_cause_register_o[CAUSE_RECOVERY_BIT];
    endproperty
    property p_dog_norst; s_dog ##0 wdog_i.reset_mode && ext_resetn_i && debug_pin_i |-> !system_reset_o[*4]; endproperty
    property p_wake; s_quiet ##1 s_move ##1 $stable(gpio_pin_i)[*6] |-> ##[0:WAKE_MAX] mode_o != MODE_SLEEP; endproperty
    property p_latch; mode_o == MODE_SLEEP && $past(mode_o) == MODE_SLEEP |-> $stable(port_input_latch_o); endproperty
    property p_hold; mode_o == MODE_RECOVER && !osc_ready_i |=> mode_o != MODE_ACTIVE; endproperty
    property p_flag;
        $past(mode_o) == MODE_RECOVER && mode_o == MODE_ACTIVE |-> reset_cause_register_o[CAUSE_RECOVERY_BIT];
    endproperty
    a_enter: assert property (p_enter) else $error("sleep not entered");
    a_off: assert property (p_off) else $error("clock or core running asleep");
    a_dog_keep: assert property (p_dog_keep) else $error("watchdog power wrong");
    a_bo_amp: assert property (p_bo_amp) else $error("brownout or amp wrong");
    a_idle: assert property (p_idle) else $error("idle power wrong");
    a_ext: assert property (p_ext) else $error("no reset on ext pin");
    a_dbg: assert property (p_dbg) else $error("no reset on debug pin");
    a_dog_cause: assert property (p_dog_cause) else $error("watchdog causes unset");
    a_dog_norst: assert property (p_dog_norst) else $error("watchdog gave reset");
    a_wake: assert property (p_wake) else $error("pin change did not wake");
    a_latch: assert property (p_latch) else $error("latch moved asleep");
    a_hold: assert property (p_hold) else $error("released before osc");
    a_flag: assert property (p_flag) else $error("recovery flag unset");
endmodule
bind sleep_wake_ctrl sleep_wake_checker #(.GPIO_W(GPIO_W), .MIN_PULSE(MIN_PULSE)) chk (.sys_clk_i, .rstn_i,
    .sleep_req_i, .wdog_i, .gpio_pin_i, .gpio_wake_en_i, .ext_resetn_i, .debug_pin_i, .brownout_sleep_opt_i,
    .amp_sleep_en_i, .osc_ready_i, .power_o, .port_input_latch_o, .reset_cause_register_o, .system_reset_o, .mode_o);

// >>> testbench/wake_side_model.sv
/* Far-side model: wake pins and oscillator start-up.
   Assumes the bench pulses a flip mask and reports when the block sleeps. */
`timescale 1ns/1ps
module wake_side_model (
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] flip_i,
    input  wire logic       asleep_i,
    input  wire logic       slow_i,
    output logic      [7:0] pins_o,
    output logic            osc_ready_o
);
    logic [3:0] warm_r;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_o <= 8'h00;
        end else begin
            pins_o <= pins_o ^ flip_i;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            warm_r <= 4'hF;
        end else if (asleep_i) begin
            warm_r <= 4'h0;
        end else if (warm_r != 4'hF) begin
            warm_r <= warm_r + 4'h1;
        end
    end
    assign osc_ready_o = slow_i ? (warm_r > 4'h8) : (warm_r != 4'h0);
endmodule
